// >>> verilog/irq_routing_and_shadow_regs.v
// Interrupt routing control, forced media change and write-only shadows.
// Assumes a synchronous register port with read data one cycle after the strobe,
// and event sources that are synchronous active-high levels.
//
// Contract
// - Bit 0 picks serial frame or pins
// - Bit 0 leaves RTC, SMI alone, and SCI except on IRQ14/15 pins
// - Parallel mode: no BIOS buffer, IRQ15/IRQ14 pins
// - Bit 1 routes RTC interrupt
// - Bit 2 routes SCI
// - No frame delivery on standby supply
// - Bit 3 sets SCI polarity
// - Bit 4 sets SCI push-pull or open drain
// - Bits 6:5 pick shared pin function
// - Bit 5 overrides configured SCI number
// - Shared pin driver follows its function
// - Bit 7 routes SMI, frame slot two
// - SMI pin style from GPIO configuration
// - Software sets force bits, never clears
// - Step with select clears that force bit
// - Change status ORs selected forces, input
// - Force bits 0,1; others read zero
// - Floppy rate shadow readable
// - First UART FIFO shadow readable
// - Second UART FIFO shadow readable
`timescale 1ns/1ps
`default_nettype none
`include "irq_route_regs.vh"

module irq_routing_and_shadow_regs #(
  parameter LEGACY_IRQS = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Snooped writes of write-only core registers
  input wire rate_sel_wr,
  input wire uart_a_fifo_wr,
  input wire uart_b_fifo_wr,
  input wire [7:0] core_wdata,
  // Power state
  input wire standby_supply,
  // Interrupt sources, active high
  input wire [LEGACY_IRQS-1:0] legacy_irq,
  input wire rtc_irq,
  input wire sci_event,
  input wire smi_event,
  input wire pme_event,
  input wire [3:0] sci_cfg_irq,
  // GPIO configuration of the management pin
  input wire smi_pin_active_high,
  input wire smi_pin_open_drain,
  // Floppy drive interface
  input wire head_step_n,
  input wire drive_select0_n,
  input wire drive_select1_n,
  input wire media_changed_in_n,
  output wire media_changed_status,
  // Serial frame requests
  output reg [LEGACY_IRQS-1:0] frame_irq_req,
  // Parallel IRQ pins
  output reg [LEGACY_IRQS-1:0] irq_pin_out,
  output reg [LEGACY_IRQS-1:0] irq_pin_oe,
  // Dual-use serial line and bus clock pins
  output wire serial_interrupt_line_en,
  output wire bus_clock_in_en,
  output wire bios_buffer_en,
  // Shared event pin
  output reg power_event_out_n,
  output reg power_event_oe,
  // Management pin
  output reg sysmgmt_pin_n,
  output reg sysmgmt_pin_oe,
  // Effective SCI number
  output wire [3:0] sci_irq_num
);

  // ****************************************************************
  // Routing register
  // ****************************************************************
  reg [7:0] route_reg;
  wire sel_route;
  wire sel_force;
  wire [1:0] shared_sel;
  wire parallel_mode;
  wire frame_ok;

  assign sel_route = reg_addr == `OFS_ROUTE;
  assign sel_force = reg_addr == `OFS_FORCE;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      route_reg <= `ROUTE_RESET;
    end else if (reg_wr && sel_route) begin
      route_reg <= reg_wdata;
    end
  end

  assign parallel_mode = route_reg[`ROUTE_PARALLEL];
  assign shared_sel = route_reg[`ROUTE_SHARED_HI:`ROUTE_SHARED_LO];
  assign frame_ok = ~standby_supply;

  // Pin repurposing in parallel mode
  assign bios_buffer_en = ~parallel_mode;
  assign serial_interrupt_line_en = ~parallel_mode;
  assign bus_clock_in_en = ~parallel_mode;

  // Bit 5 takes SCI off the configured number; only code 01 puts it on the shared pin
  assign sci_irq_num = route_reg[`ROUTE_SHARED_LO] ? 4'h0 : sci_cfg_irq;

  // ****************************************************************
  // SCI level and shared pin
  // ****************************************************************
  wire sci_level;
  wire sci_on_shared;
  wire sci_on_number;

  // Driven level of SCI after polarity
  assign sci_level = route_reg[`ROUTE_SCI_POL] ? sci_event : ~sci_event;
  assign sci_on_shared = shared_sel == `SHARED_SCI;
  assign sci_on_number = ~route_reg[`ROUTE_SHARED_LO] && (sci_cfg_irq != 4'h0);

  // Reserved code 11 leaves the pin undriven
  always @* begin
    power_event_out_n = 1'b1;
    power_event_oe = 1'b0;
    case (shared_sel)
      `SHARED_PME: begin
        power_event_out_n = 1'b0;
        power_event_oe = pme_event;
      end
      `SHARED_SCI: begin
        power_event_out_n = sci_level;
        power_event_oe = route_reg[`ROUTE_SCI_OD] ? ~sci_level : 1'b1;
      end
      `SHARED_IRQ9: begin
        power_event_out_n = legacy_irq[9];
        power_event_oe = 1'b1;
      end
      default: begin
        power_event_out_n = 1'b1;
        power_event_oe = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Frame requests and parallel pins
  // ****************************************************************
  reg [LEGACY_IRQS-1:0] frame_next;
  reg [LEGACY_IRQS-1:0] pin_next;
  reg [LEGACY_IRQS-1:0] pin_oe_next;
  integer n;

  always @* begin
    frame_next = {LEGACY_IRQS{1'b0}};
    pin_next = {LEGACY_IRQS{1'b0}};
    pin_oe_next = {LEGACY_IRQS{1'b0}};
    for (n = 0; n < LEGACY_IRQS; n = n + 1) begin
      // Legacy sources only follow bit 0
      if (parallel_mode) begin
        pin_next[n] = legacy_irq[n];
        pin_oe_next[n] = 1'b1;
      end else begin
        frame_next[n] = legacy_irq[n] & frame_ok;
      end
    end
    // RTC on slot eight, by its own select only
    if (route_reg[`ROUTE_RTC_PIN]) begin
      pin_next[8] = rtc_irq;
      pin_oe_next[8] = 1'b1;
      frame_next[8] = 1'b0;
    end else begin
      frame_next[8] = rtc_irq & frame_ok;
      pin_next[8] = 1'b0;
      pin_oe_next[8] = 1'b0;
    end
    // SCI on its configured number, by its own select only
    if (sci_on_number && !sci_on_shared) begin
      if (route_reg[`ROUTE_SCI_PIN]) begin
        pin_next[sci_irq_num] = sci_level;
        pin_oe_next[sci_irq_num] = route_reg[`ROUTE_SCI_OD] ? ~sci_level : 1'b1;
      end else begin
        frame_next[sci_irq_num] = frame_next[sci_irq_num] | (sci_event & frame_ok);
      end
    end
    // SMI in slot two when not on its own pin
    if (!route_reg[`ROUTE_SMI_PIN]) begin
      frame_next[2] = frame_next[2] | (smi_event & frame_ok);
    end
    // The two repurposed pins carry IRQ14/15 only in parallel mode
    if (!parallel_mode) begin
      pin_oe_next[14] = 1'b0;
      pin_oe_next[15] = 1'b0;
    end
  end

  // Registered outputs give one cycle of latency from sources
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frame_irq_req <= {LEGACY_IRQS{1'b0}};
      irq_pin_out <= {LEGACY_IRQS{1'b0}};
      irq_pin_oe <= {LEGACY_IRQS{1'b0}};
    end else begin
      frame_irq_req <= frame_next;
      irq_pin_out <= pin_next;
      irq_pin_oe <= pin_oe_next;
    end
  end

  // ****************************************************************
  // Management pin
  // ****************************************************************
  wire smi_driven_level;

  // Style comes from GPIO config, not from the routing register
  assign smi_driven_level = smi_pin_active_high ? smi_event : ~smi_event;

  always @* begin
    sysmgmt_pin_n = 1'b1;
    sysmgmt_pin_oe = 1'b0;
    if (route_reg[`ROUTE_SMI_PIN]) begin
      sysmgmt_pin_n = smi_driven_level;
      sysmgmt_pin_oe = smi_pin_open_drain ? ~smi_driven_level : 1'b1;
    end
  end

  // ****************************************************************
  // Forced media change
  // ****************************************************************
  wire [1:0] force_bits;

  drive_change_force u_force (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .set_en(reg_wr && sel_force),
    .set_bits(reg_wdata[`FORCE_DRIVE1:`FORCE_DRIVE0]),
    .head_step_n(head_step_n),
    .drive_select0_n(drive_select0_n),
    .drive_select1_n(drive_select1_n),
    .media_changed_in_n(media_changed_in_n),
    .force_reg(force_bits),
    .media_changed_status(media_changed_status)
  );

  // ****************************************************************
  // Shadows
  // ****************************************************************
  // Core writes are snooped; register port writes to shadows do nothing
  reg [1:0] shadow_wr_idx;
  reg [1:0] shadow_rd_idx;
  wire shadow_wr;
  wire [7:0] shadow_rdata;

  assign shadow_wr = rate_sel_wr | uart_a_fifo_wr | uart_b_fifo_wr;

  // Simultaneous core writes: lowest index wins, others lost
  always @* begin
    shadow_wr_idx = 2'h0;
    if (rate_sel_wr) begin
      shadow_wr_idx = 2'h0;
    end else if (uart_a_fifo_wr) begin
      shadow_wr_idx = 2'h1;
    end else if (uart_b_fifo_wr) begin
      shadow_wr_idx = 2'h2;
    end
  end

  always @* begin
    case (reg_addr)
      `OFS_RATE_SHADOW: shadow_rd_idx = 2'h0;
      `OFS_UART_A_SHADOW: shadow_rd_idx = 2'h1;
      `OFS_UART_B_SHADOW: shadow_rd_idx = 2'h2;
      default: shadow_rd_idx = 2'h3;
    endcase
  end

  shadow_store #(
    .WIDTH(8),
    .DEPTH(3)
  ) u_shadow (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wr_en(shadow_wr),
    .wr_idx(shadow_wr_idx),
    .wr_data(core_wdata),
    .rd_idx(shadow_rd_idx),
    .rd_data(shadow_rdata)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  reg [7:0] rd_addr_reg;
  reg rd_pending_reg;
  reg [7:0] local_rdata_reg;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_addr_reg <= 8'h00;
      rd_pending_reg <= 1'b0;
      local_rdata_reg <= 8'h00;
    end else begin
      rd_pending_reg <= reg_rd;
      rd_addr_reg <= reg_addr;
      if (sel_route) begin
        local_rdata_reg <= route_reg;
      end else if (sel_force) begin
        local_rdata_reg <= {6'h00, force_bits};
      end else begin
        local_rdata_reg <= 8'h00;
      end
    end
  end

  // Unmapped addresses and idle cycles read zero
  always @* begin
    reg_rdata = 8'h00;
    if (rd_pending_reg) begin
      case (rd_addr_reg)
        `OFS_ROUTE: reg_rdata = local_rdata_reg;
        `OFS_FORCE: reg_rdata = local_rdata_reg;
        `OFS_RATE_SHADOW: reg_rdata = shadow_rdata;
        `OFS_UART_A_SHADOW: reg_rdata = shadow_rdata;
        `OFS_UART_B_SHADOW: reg_rdata = shadow_rdata;
        default: reg_rdata = 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> verilog/irq_route_regs.vh
// Register offsets, field positions and reset values of the routing and shadow bank.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef IRQ_ROUTE_REGS_VH
`define IRQ_ROUTE_REGS_VH

// ****************************************************************
// Offsets
// ****************************************************************
`define OFS_ROUTE 8'hC0
`define OFS_FORCE 8'hC1
`define OFS_RATE_SHADOW 8'hC2
`define OFS_UART_A_SHADOW 8'hC3
`define OFS_UART_B_SHADOW 8'hC4

// ****************************************************************
// Routing register fields
// ****************************************************************
`define ROUTE_PARALLEL 0
`define ROUTE_RTC_PIN 1
`define ROUTE_SCI_PIN 2
`define ROUTE_SCI_POL 3
`define ROUTE_SCI_OD 4
`define ROUTE_SHARED_LO 5
`define ROUTE_SHARED_HI 6
`define ROUTE_SMI_PIN 7
`define SHARED_PME 2'h0
`define SHARED_SCI 2'h1
`define SHARED_IRQ9 2'h2

// ****************************************************************
// Forced change fields and reset values
// ****************************************************************
`define FORCE_DRIVE0 0
`define FORCE_DRIVE1 1
`define ROUTE_RESET 8'h00
`define FORCE_RESET 2'h3
`define SHADOW_RESET 8'h00

`endif

// >>> verilog/shadow_store.v
// Three-entry shadow memory for write-only values of neighbouring cores.
// Assumes one write port and one registered read port on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "irq_route_regs.vh"

module shadow_store #(
  parameter WIDTH = 8,
  parameter DEPTH = 3
) (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Write port
  input wire wr_en,
  input wire [1:0] wr_idx,
  input wire [WIDTH-1:0] wr_data,
  // Read port
  input wire [1:0] rd_idx,
  output reg [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  genvar i;

  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          mem_reg[i] <= `SHADOW_RESET;
        end else if (wr_en && wr_idx == i) begin
          mem_reg[i] <= wr_data;
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= `SHADOW_RESET;
    end else if (rd_idx < DEPTH) begin
      rd_data <= mem_reg[rd_idx];
    end else begin
      rd_data <= `SHADOW_RESET;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/drive_change_force.v
// Sticky per-drive forced media-change flags with hardware clearing.
// Assumes step and selects are synchronous, active-low levels from the floppy core.
`timescale 1ns/1ps
`default_nettype none
`include "irq_route_regs.vh"

module drive_change_force (
  // Clock and reset
  input wire ref_clk,
  input wire resetn,
  // Software set
  input wire set_en,
  input wire [1:0] set_bits,
  // Drive signals
  input wire head_step_n,
  input wire drive_select0_n,
  input wire drive_select1_n,
  input wire media_changed_in_n,
  // Results
  output reg [1:0] force_reg,
  output wire media_changed_status
);

  wire [1:0] sel;
  wire [1:0] clr;
  reg [1:0] force_next;

  assign sel = {~drive_select1_n, ~drive_select0_n};
  assign clr = sel & {2{~head_step_n}};

  // Writing zero never clears; a set in the clearing cycle wins
  always @* begin
    force_next = (force_reg & ~clr) | (set_en ? set_bits : 2'h0);
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      force_reg <= `FORCE_RESET;
    end else begin
      force_reg <= force_next;
    end
  end

  // Forcing only touches the drive currently selected
  assign media_changed_status = |(sel & force_reg) | ~media_changed_in_n;

endmodule
`default_nettype wire

// >>> test/irq_routing_and_shadow_regs_properties.sv
// Checker for the routing and shadow bank, bound to its top module.
// Assumes the routing byte is changed only through the register port.
`timescale 1ns/1ps
`default_nettype none
module irq_bank_checker #(parameter LEGACY_IRQS = 16) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Sources
  input wire logic standby_supply,
  input wire logic [LEGACY_IRQS-1:0] legacy_irq,
  input wire logic rtc_irq,
  input wire logic smi_event,
  input wire logic pme_event,
  input wire logic [3:0] sci_cfg_irq,
  input wire logic media_changed_in_n,
  // Results
  input wire logic media_changed_status,
  input wire logic [LEGACY_IRQS-1:0] frame_irq_req,
  input wire logic bios_buffer_en,
  input wire logic power_event_out_n,
  input wire logic power_event_oe,
  input wire logic [3:0] sci_irq_num
);
  logic [7:0] route_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Own copy, since the routing byte is not a port
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      route_reg <= 8'h00;
    else if (reg_wr && reg_addr == 8'hC0)
      route_reg <= reg_wdata;
  end
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  chk_force_reserved: assert property (reg_rd && reg_addr == 8'hC1 |=> reg_rdata[7:2] == 6'h00)
    else $error("reserved force bits not zero");
  chk_bios_mode: assert property (bios_buffer_en == !route_reg[0])
    else $error("bios buffer enable wrong");
  chk_sci_override: assert property (sci_irq_num == (route_reg[5] ? 4'h0 : sci_cfg_irq))
    else $error("sci number wrong");
  chk_rtc_frame: assert property (!standby_supply && !route_reg[1] && rtc_irq |=> frame_irq_req[8])
    else $error("rtc frame request missing");
  chk_smi_frame: assert property (!standby_supply && !route_reg[7] && smi_event |=> frame_irq_req[2])
    else $error("smi frame request missing");
  chk_standby_mute: assert property (standby_supply |=> frame_irq_req == '0)
    else $error("frame request on standby");
  chk_change_input: assert property (!media_changed_in_n |-> media_changed_status)
    else $error("media change input not passed");
  chk_pme_pin: assert property (route_reg[6:5] == 2'h0 |->
    power_event_oe == pme_event && (!pme_event || !power_event_out_n))
    else $error("power event pin wrong");
  chk_irq9_pin: assert property (route_reg[6:5] == 2'h2 |->
    power_event_oe && power_event_out_n == legacy_irq[9])
    else $error("irq9 pin wrong");
  cover property (reg_rd && reg_addr == 8'hC2);
  cover property (route_reg[0] && route_reg[7]);
  cover property (standby_supply && rtc_irq);
endmodule
bind irq_routing_and_shadow_regs irq_bank_checker #(.LEGACY_IRQS(LEGACY_IRQS)) u_chk (
  .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .standby_supply, .legacy_irq, .rtc_irq, .smi_event, .pme_event, .sci_cfg_irq,
  .media_changed_in_n, .media_changed_status, .frame_irq_req, .bios_buffer_en,
  .power_event_out_n, .power_event_oe, .sci_irq_num);
`default_nettype wire

// >>> test/host_irq_sink.sv
// Chipset side of the shared event and management pins.
// Assumes board pull-ups on both lines.
`timescale 1ns/1ps
`default_nettype none
module host_irq_sink (
  // Pin drivers of the bank
  input wire logic power_event_out_n,
  input wire logic power_event_oe,
  input wire logic sysmgmt_pin_n,
  input wire logic sysmgmt_pin_oe,
  // Levels seen by the chipset
  output wire logic event_line,
  output wire logic mgmt_line
);
  // Released open-drain lines float high
  assign event_line = power_event_oe ? power_event_out_n : 1'b1;
  assign mgmt_line = sysmgmt_pin_oe ? sysmgmt_pin_n : 1'b1;
endmodule
`default_nettype wire

// >>> test/irq_routing_and_shadow_regs_tb.sv
// Self-checking bench of the routing and shadow bank against a small model.
// Assumes the bank header is on the include path.
`timescale 1ns/1ps
`default_nettype none
module irq_routing_and_shadow_regs_tb;
  logic ref_clk, resetn, reg_wr, reg_rd, rate_sel_wr, uart_a_fifo_wr, uart_b_fifo_wr;
  logic standby_supply, rtc_irq, sci_event, smi_event, pme_event, media_changed_status;
  logic head_step_n, drive_select0_n, drive_select1_n, media_changed_in_n, bios_buffer_en;
  logic power_event_out_n, power_event_oe, sysmgmt_pin_n, sysmgmt_pin_oe, event_line, mgmt_line;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, core_wdata;
  logic [15:0] legacy_irq, frame_irq_req;
  logic [3:0] sci_cfg_irq, sci_irq_num;
  logic smi_pin_active_high, smi_pin_open_drain, serial_interrupt_line_en, bus_clock_in_en;
  logic lvl, smi_lvl;
  logic [15:0] irq_pin_out, irq_pin_oe, fr_m, pin_m, oe_m;
  logic [31:0] seed = 32'h46FBFAC6;
  int n_fail = 0;
  int checks_done = 0;
  int route_m = 0;
  int shadow_m [3] = '{0, 0, 0};
  irq_routing_and_shadow_regs dut (
    .ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rate_sel_wr, .uart_a_fifo_wr, .uart_b_fifo_wr, .core_wdata, .standby_supply,
    .legacy_irq, .rtc_irq, .sci_event, .smi_event, .pme_event, .sci_cfg_irq,
    .smi_pin_active_high, .smi_pin_open_drain, .head_step_n,
    .drive_select0_n, .drive_select1_n, .media_changed_in_n, .media_changed_status,
    .frame_irq_req, .irq_pin_out, .irq_pin_oe, .serial_interrupt_line_en,
    .bus_clock_in_en, .bios_buffer_en, .power_event_out_n, .power_event_oe,
    .sysmgmt_pin_n, .sysmgmt_pin_oe, .sci_irq_num);
  host_irq_sink host (.power_event_out_n, .power_event_oe, .sysmgmt_pin_n,
    .sysmgmt_pin_oe, .event_line, .mgmt_line);
  // ********
  // Helpers
  // ********
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic core(input int k, input logic [7:0] d);
    @(posedge ref_clk);
    core_wdata <= d;
    rate_sel_wr <= (k == 0);
    uart_a_fifo_wr <= (k == 1);
    uart_b_fifo_wr <= (k == 2);
    @(posedge ref_clk);
    {rate_sel_wr, uart_a_fifo_wr, uart_b_fifo_wr} <= 3'b000;
    shadow_m[k] = d;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Far beyond the fewer than a hundred cycles the sequence needs
  initial begin
    #100000;
    n_fail++;
    conclude();
  end
  // ********
  // Sequence
  // ********
  initial begin
    resetn = 1'b0;
    {reg_wr, reg_rd, rate_sel_wr, uart_a_fifo_wr, uart_b_fifo_wr} = '0;
    {reg_addr, reg_wdata, core_wdata, legacy_irq} = '0;
    {standby_supply, rtc_irq, sci_event, smi_event, pme_event} = '0;
    {smi_pin_active_high, smi_pin_open_drain} = 2'b01;
    sci_cfg_irq = 4'h5;
    {head_step_n, drive_select0_n, drive_select1_n, media_changed_in_n} = 4'hF;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(8'hC0, 8'h00);
    rd(8'hC1, 8'h03);
    for (int k = 0; k < 3; k++) rd(8'(8'hC2 + k), 8'h00);
    rd(8'hC7, 8'h00);
    // Odd SCI numbers keep slots 2 and 8 free for RTC and SMI
    repeat (8) begin
      route_m = xs() & 32'hFF;
      legacy_irq <= 16'(xs() & 32'hFEFB);
      sci_cfg_irq <= 4'(xs()) | 4'h1;
      {rtc_irq, smi_event, pme_event, sci_event} <= 4'(xs());
      {smi_pin_active_high, smi_pin_open_drain} <= 2'(xs());
      wr(8'hC0, 8'(route_m));
      rd(8'hC0, 8'(route_m));
      chk(bios_buffer_en, !route_m[0]);
      chk(serial_interrupt_line_en, !route_m[0]);
      chk(bus_clock_in_en, !route_m[0]);
      chk(sci_irq_num, route_m[5] ? 4'h0 : sci_cfg_irq);
      chk(frame_irq_req[8], !route_m[1] && rtc_irq);
      chk(frame_irq_req[2], !route_m[7] && smi_event);
      smi_lvl = smi_event == smi_pin_active_high;
      chk(mgmt_line, !route_m[7] || smi_lvl);
      chk(sysmgmt_pin_oe, route_m[7] && (!smi_pin_open_drain || !smi_lvl));
      // Slot and pin vectors rebuilt from the routing rules
      lvl = sci_event == route_m[3];
      fr_m = route_m[0] ? 16'h0000 : legacy_irq;
      pin_m = route_m[0] ? legacy_irq : 16'h0000;
      oe_m = route_m[0] ? 16'hFFFF : 16'h0000;
      fr_m[8] = !route_m[1] && rtc_irq;
      pin_m[8] = route_m[1] && rtc_irq;
      oe_m[8] = route_m[1];
      if (!route_m[5] && route_m[2]) begin
        pin_m[sci_cfg_irq] = lvl;
        oe_m[sci_cfg_irq] = !route_m[4] || !lvl;
      end
      if (!route_m[5] && !route_m[2]) fr_m[sci_cfg_irq] = fr_m[sci_cfg_irq] | sci_event;
      fr_m[2] = fr_m[2] | (!route_m[7] && smi_event);
      if (!route_m[0]) oe_m[15:14] = 2'b00;
      chk(frame_irq_req, fr_m);
      chk(irq_pin_out, pin_m);
      chk(irq_pin_oe, oe_m);
      // Reserved code is driven too: the shared pin must stay released
      case (route_m[6:5])
        0: chk(event_line, !pme_event);
        1: begin
          chk(event_line, sci_event == route_m[3]);
          chk(power_event_oe, !route_m[4] || sci_event != route_m[3]);
        end
        2: chk(event_line, legacy_irq[9]);
        default: chk(power_event_oe, 1'b0);
      endcase
    end
    standby_supply <= 1'b1;
    rtc_irq <= 1'b1;
    wr(8'hC0, 8'h00);
    @(posedge ref_clk);
    #1 chk(frame_irq_req, 16'h0000);
    standby_supply <= 1'b0;
    // Force bits: zero writes ignored, step with select clears
    wr(8'hC1, 8'h00);
    rd(8'hC1, 8'h03);
    drive_select0_n <= 1'b0;
    #1 chk(media_changed_status, 1'b1);
    head_step_n <= 1'b0;
    @(posedge ref_clk);
    head_step_n <= 1'b1;
    rd(8'hC1, 8'h02);
    chk(media_changed_status, 1'b0);
    drive_select0_n <= 1'b1;
    drive_select1_n <= 1'b0;
    head_step_n <= 1'b0;
    @(posedge ref_clk);
    head_step_n <= 1'b1;
    rd(8'hC1, 8'h00);
    media_changed_in_n <= 1'b0;
    wr(8'hC1, 8'hFF);
    rd(8'hC1, 8'h03);
    chk(media_changed_status, 1'b1);
    for (int k = 0; k < 3; k++) begin
      core(k, 8'(xs()));
      wr(8'(8'hC2 + k), 8'h5A);
      rd(8'(8'hC2 + k), 8'(shadow_m[k]));
    end
    conclude();
  end
endmodule
`default_nettype wire
